// ===== inc/ext_irq_pkg.sv
package ext_irq_pkg;

    localparam int unsigned LINE_COUNT = 9;
    localparam int unsigned VEC_WIDTH  = 8;
    localparam int unsigned DATA_WIDTH = 32;
    localparam int unsigned ADDR_WIDTH = 5;
    localparam int unsigned EVT_WIDTH  = 2;

    // Byte offsets of the register words.
    localparam logic [ADDR_WIDTH-1:0] LINE_MASK_OFS  = 5'h00;
    localparam logic [ADDR_WIDTH-1:0] LINE_EDGE_OFS  = 5'h04;
    localparam logic [ADDR_WIDTH-1:0] LINE_POL_OFS   = 5'h08;
    localparam logic [ADDR_WIDTH-1:0] LINE_PEND_OFS  = 5'h0c;
    localparam logic [ADDR_WIDTH-1:0] EVT_STATUS_OFS = 5'h10;
    localparam logic [ADDR_WIDTH-1:0] EVT_MASK_OFS   = 5'h14;
    localparam logic [ADDR_WIDTH-1:0] CPU_CTRL_OFS   = 5'h18;

    // Event status and control register bit positions.
    localparam int unsigned EVT_NMI_BIT  = 0;
    localparam int unsigned EVT_MASK_BIT = 1;
    localparam int unsigned CTRL_GIE_BIT = 0;

    // Vector numbers handed to the processor.
    localparam logic [VEC_WIDTH-1:0] NMI_VEC       = 8'h02;
    localparam logic [VEC_WIDTH-1:0] MASK_VEC_BASE = 8'h20;

    // Reset values.
    localparam logic [LINE_COUNT-1:0] LINE_MASK_RST = 9'h1ff;
    localparam logic [LINE_COUNT-1:0] LINE_EDGE_RST = 9'h1ff;
    localparam logic [LINE_COUNT-1:0] LINE_POL_RST  = 9'h1ff;
    localparam logic [EVT_WIDTH-1:0]  EVT_MASK_RST  = 2'h0;
    localparam logic                  GIE_RST       = 1'b0;

endpackage : ext_irq_pkg

// ===== inc/req_line_if.sv
interface req_line_if;
    logic pin;
    logic edge_mode;
    logic active_high;
    logic ack;
    logic pending;

    modport ctrl (output pin, output edge_mode, output active_high, output ack, input pending);
    modport line (input pin, input edge_mode, input active_high, input ack, output pending);
endinterface : req_line_if

// ===== core/maskable_line.sv
module maskable_line (
    input  wire logic    core_clk_i,
    input  wire logic    reset_i,
    req_line_if.line     port
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic act_prev;
        logic pend;
    } line_state_type;

    line_state_type q;
    line_state_type d;
    logic           act;

    // Polarity applies after the second synchroniser stage only.
    assign act = port.active_high ? q.s2 : ~q.s2;

    always_comb begin
        d          = q;
        d.s1       = port.pin;
        d.s2       = q.s1;
        d.act_prev = act;
        if (port.ack) begin
            d.pend = 1'b0;
        end
        // A fresh edge is held until acknowledged; further edges merge into it.
        if (act && !q.act_prev) begin
            d.pend = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign port.pending = port.edge_mode ? q.pend : act;

    chk_edge_hold_pend: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (q.pend && !port.ack) |=> q.pend)
        else $error("edge request dropped before acknowledge");

    chk_edge_sets_pend: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (act && !q.act_prev) |=> q.pend)
        else $error("active edge did not set pending");

    chk_level_follows: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !port.edge_mode |-> (port.pending == (q.s2 == port.active_high)))
        else $error("level request does not follow polarity");

endmodule : maskable_line

// ===== core/ext_irq_front_end.sv
// Operation
// - Unmaskable request is the top hardware interrupt; no mask blocks it.
// - Taking the unmaskable request always yields the unmaskable vector entry.
// - Unmaskable request never enters maskable priority arbitration.
// - No pending or in-service bit exists for the unmaskable source.
// - A new unmaskable request may preempt a running unmaskable routine.
// - Taking any hardware interrupt clears the global interrupt enable.
// - Unmaskable service in progress never alters maskable prioritisation.
// - Rising unmaskable input is latched and synchronised to the clock.
// - Latched unmaskable request is taken only at an instruction boundary.
// - Nine maskable request inputs, numbered eight down to zero.
// - An unmasked maskable request vectors to its own pin's entry.
// - Maskable requests are synchronised and selectable edge or level.
// - Each maskable request has programmable active polarity.
// - Second request from one source ignored until first acknowledged.
module ext_irq_front_end #(
    parameter int unsigned N = ext_irq_pkg::LINE_COUNT
) (
    input  wire logic                                core_clk_i,
    input  wire logic                                reset_i,
    input  wire logic                                nmi_pin_i,
    input  wire logic [N-1:0]                        ext_req_i,
    input  wire logic                                instr_boundary_i,
    input  wire logic                                set_enable_i,
    input  wire logic                                clear_enable_i,
    output logic                                     take_o,
    output logic [ext_irq_pkg::VEC_WIDTH-1:0]        vector_o,
    output logic                                     global_enable_o,
    input  wire logic [ext_irq_pkg::ADDR_WIDTH-1:0]  avs_address_i,
    input  wire logic                                avs_read_i,
    input  wire logic                                avs_write_i,
    input  wire logic [ext_irq_pkg::DATA_WIDTH-1:0]  avs_writedata_i,
    output logic [ext_irq_pkg::DATA_WIDTH-1:0]       avs_readdata_o,
    output logic                                     avs_waitrequest_o,
    output logic                                     irq_o
);

    typedef struct packed {
        logic                                nmi_s1;
        logic                                nmi_s2;
        logic                                nmi_s3;
        logic                                nmi_pend;
        logic                                global_en;
        logic                                take;
        logic [ext_irq_pkg::VEC_WIDTH-1:0]   vector;
        logic [N-1:0]                        line_mask;
        logic [N-1:0]                        line_edge;
        logic [N-1:0]                        line_pol;
        logic [ext_irq_pkg::EVT_WIDTH-1:0]   evt_status;
        logic [ext_irq_pkg::EVT_WIDTH-1:0]   evt_mask;
        logic                                rd_done;
        logic [ext_irq_pkg::DATA_WIDTH-1:0]  rdata;
    } state_type;

    state_type                           q;
    state_type                           d;
    logic [N-1:0]                        line_pend;
    logic [N-1:0]                        line_ack;
    logic [N-1:0]                        cand;
    logic                                mask_sel_valid;
    logic [3:0]                          mask_sel;
    logic                                nmi_edge;
    logic                                take_nmi;
    logic                                take_mask;
    logic                                rd_accept;
    logic [ext_irq_pkg::DATA_WIDTH-1:0]  rd_mux;

    req_line_if lines[N] ();

    for (genvar g = 0; g < N; g++) begin : g_line
        assign lines[g].pin         = ext_req_i[g];
        assign lines[g].edge_mode   = q.line_edge[g];
        assign lines[g].active_high = q.line_pol[g];
        assign lines[g].ack         = line_ack[g];
        assign line_pend[g]         = lines[g].pending;

        maskable_line u_line (
            .core_clk_i (core_clk_i),
            .reset_i    (reset_i),
            .port       (lines[g].line)
        );
    end

    // The second and third stage outputs feed the edge detector.
    assign nmi_edge  = q.nmi_s2 && !q.nmi_s3;
    assign take_nmi  = instr_boundary_i && q.nmi_pend;
    assign cand      = line_pend & ~q.line_mask;
    // Maskable take looks at the unmasked lines, the global enable and the unmaskable latch, which blocks it.
    assign take_mask = instr_boundary_i && !q.nmi_pend && q.global_en && mask_sel_valid;
    assign rd_accept = avs_read_i && q.rd_done;

    always_comb begin
        mask_sel_valid = 1'b0;
        mask_sel       = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (cand[i]) begin
                mask_sel_valid = 1'b1;
                mask_sel       = 4'(i);
            end
        end
    end

    always_comb begin
        line_ack = '0;
        if (take_mask) begin
            line_ack[mask_sel] = 1'b1;
        end
    end

    always_comb begin
        rd_mux = '0;
        case (avs_address_i)
            ext_irq_pkg::LINE_MASK_OFS:  rd_mux[N-1:0] = q.line_mask;
            ext_irq_pkg::LINE_EDGE_OFS:  rd_mux[N-1:0] = q.line_edge;
            ext_irq_pkg::LINE_POL_OFS:   rd_mux[N-1:0] = q.line_pol;
            // Maskable lines only; the unmaskable source has no bit here.
            ext_irq_pkg::LINE_PEND_OFS:  rd_mux[N-1:0] = line_pend;
            ext_irq_pkg::EVT_STATUS_OFS: rd_mux[ext_irq_pkg::EVT_WIDTH-1:0] = q.evt_status;
            ext_irq_pkg::EVT_MASK_OFS:   rd_mux[ext_irq_pkg::EVT_WIDTH-1:0] = q.evt_mask;
            ext_irq_pkg::CPU_CTRL_OFS:   rd_mux[ext_irq_pkg::CTRL_GIE_BIT] = q.global_en;
            default:                     rd_mux = '0;
        endcase
    end

    always_comb begin
        d        = q;
        d.nmi_s1 = nmi_pin_i;
        d.nmi_s2 = q.nmi_s1;
        d.nmi_s3 = q.nmi_s2;
        d.take   = 1'b0;

        if (take_nmi) begin
            d.nmi_pend = 1'b0;
        end
        // A new edge wins over the clear, so a preempting request is kept.
        if (nmi_edge) begin
            d.nmi_pend = 1'b1;
        end

        if (set_enable_i) begin
            d.global_en = 1'b1;
        end
        if (clear_enable_i) begin
            d.global_en = 1'b0;
        end

        if (take_nmi) begin
            d.take   = 1'b1;
            d.vector = ext_irq_pkg::NMI_VEC;
        end else if (take_mask) begin
            d.take   = 1'b1;
            d.vector = ext_irq_pkg::MASK_VEC_BASE + ext_irq_pkg::VEC_WIDTH'(mask_sel);
        end
        if (take_nmi || take_mask) begin
            d.global_en = 1'b0;
        end

        if (avs_write_i) begin
            case (avs_address_i)
                ext_irq_pkg::LINE_MASK_OFS: d.line_mask = avs_writedata_i[N-1:0];
                ext_irq_pkg::LINE_EDGE_OFS: d.line_edge = avs_writedata_i[N-1:0];
                ext_irq_pkg::LINE_POL_OFS:  d.line_pol  = avs_writedata_i[N-1:0];
                ext_irq_pkg::EVT_MASK_OFS:  d.evt_mask  = avs_writedata_i[ext_irq_pkg::EVT_WIDTH-1:0];
                default:                    d.rd_done   = q.rd_done;
            endcase
        end

        d.rd_done = avs_read_i && !q.rd_done;
        if (avs_read_i && !q.rd_done) begin
            d.rdata = rd_mux;
        end
        // Only bits that were returned are cleared; later events survive.
        if (rd_accept && avs_address_i == ext_irq_pkg::EVT_STATUS_OFS) begin
            d.evt_status = q.evt_status & ~q.rdata[ext_irq_pkg::EVT_WIDTH-1:0];
        end
        if (take_nmi) begin
            d.evt_status[ext_irq_pkg::EVT_NMI_BIT] = 1'b1;
        end
        if (take_mask) begin
            d.evt_status[ext_irq_pkg::EVT_MASK_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            q           <= '0;
            q.line_mask <= ext_irq_pkg::LINE_MASK_RST;
            q.line_edge <= ext_irq_pkg::LINE_EDGE_RST;
            q.line_pol  <= ext_irq_pkg::LINE_POL_RST;
            q.evt_mask  <= ext_irq_pkg::EVT_MASK_RST;
            q.global_en <= ext_irq_pkg::GIE_RST;
        end else begin
            q <= d;
        end
    end

    assign take_o            = q.take;
    assign vector_o          = q.vector;
    assign global_enable_o   = q.global_en;
    assign avs_readdata_o    = q.rdata;
    assign avs_waitrequest_o = avs_read_i && !q.rd_done;
    assign irq_o             = |(q.evt_status & q.evt_mask);

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    // Unmaskable path: latch, boundary, vector and preemption.
    chk_nmi_edge_latch: assert property (
        nmi_edge |=> q.nmi_pend)
        else $error("rising unmaskable edge was not latched");

    chk_nmi_only_edge: assert property (
        (!nmi_edge && !q.nmi_pend) |=> !q.nmi_pend)
        else $error("unmaskable latch set without an edge");

    chk_nmi_from_latch: assert property (
        (take_o && vector_o == ext_irq_pkg::NMI_VEC) |-> $past(q.nmi_pend))
        else $error("unmaskable vector without a latched request");

    chk_take_at_boundary: assert property (
        take_o |-> $past(instr_boundary_i))
        else $error("interrupt taken away from an instruction boundary");

    chk_no_take_idle: assert property (
        !instr_boundary_i |=> !take_o)
        else $error("interrupt taken with no instruction boundary");

    chk_nmi_pend_waits: assert property (
        (q.nmi_pend && !instr_boundary_i) |=> q.nmi_pend)
        else $error("latched unmaskable request lost before a boundary");

    chk_nmi_vector_out: assert property (
        (instr_boundary_i && q.nmi_pend) |=> (take_o && vector_o == ext_irq_pkg::NMI_VEC))
        else $error("unmaskable request did not yield its vector");

    chk_nmi_no_mask: assert property (
        (instr_boundary_i && q.nmi_pend && !q.global_en && (q.line_mask == '1)) |=> take_o)
        else $error("unmaskable request was blocked");

    chk_nmi_over_mask: assert property (
        (instr_boundary_i && q.nmi_pend && (cand != '0)) |=> vector_o == ext_irq_pkg::NMI_VEC)
        else $error("maskable source displaced the unmaskable request");

    chk_mask_yields_nmi: assert property (
        (instr_boundary_i && q.nmi_pend) |-> !take_mask)
        else $error("maskable arbitration ran beside the unmaskable request");

    chk_mask_nmi_first: assert property (
        (take_o && vector_o != ext_irq_pkg::NMI_VEC) |-> !$past(q.nmi_pend))
        else $error("maskable request taken over a latched unmaskable one");

    chk_nmi_pend_clear: assert property (
        (take_nmi && !nmi_edge) |=> !q.nmi_pend)
        else $error("unmaskable latch not cleared on transfer");

    chk_take_single: assert property (
        (take_o && !q.nmi_pend) |=> !take_o)
        else $error("one request produced two transfers");

    chk_nmi_preempt: assert property (
        (take_nmi && nmi_edge) |=> q.nmi_pend)
        else $error("edge during the transfer was lost");

    // Maskable path, arbitration order and the global enable.
    chk_take_clears_gie: assert property (
        take_o |-> !global_enable_o)
        else $error("global enable left set after taking an interrupt");

    chk_gie_take_wins: assert property (
        ((take_nmi || take_mask) && set_enable_i) |=> !global_enable_o)
        else $error("set enable overrode the transfer");

    chk_gie_blocks_mask: assert property (
        (instr_boundary_i && !q.nmi_pend && !q.global_en) |=> !take_o)
        else $error("maskable request taken while disabled");

    chk_gie_stays_off: assert property (
        (!global_enable_o && !set_enable_i) |=> !global_enable_o)
        else $error("global enable rose without a set");

    chk_gie_set: assert property (
        (set_enable_i && !clear_enable_i && !take_nmi && !take_mask) |=> global_enable_o)
        else $error("set enable did not raise the global enable");

    chk_mask_needs_gie: assert property (
        (take_o && vector_o != ext_irq_pkg::NMI_VEC) |-> $past(q.global_en))
        else $error("maskable request taken while globally disabled");

    chk_mask_gie_path: assert property (
        (instr_boundary_i && !q.nmi_pend && q.global_en && cand[0])
        |=> (take_o && vector_o == ext_irq_pkg::MASK_VEC_BASE))
        else $error("unmasked line zero not vectored");

    chk_masked_no_take: assert property (
        (instr_boundary_i && !q.nmi_pend && (cand == '0)) |=> !take_o)
        else $error("transfer taken with no unmasked request");

    chk_lowest_line: assert property (
        take_mask |-> (cand[mask_sel] && ((cand & ((N'(1) << mask_sel) - N'(1))) == '0)))
        else $error("maskable arbitration skipped a lower line");

    chk_vec_range: assert property (
        (take_o && vector_o != ext_irq_pkg::NMI_VEC)
        |-> (vector_o >= ext_irq_pkg::MASK_VEC_BASE && vector_o < ext_irq_pkg::MASK_VEC_BASE + N))
        else $error("maskable vector outside the nine pin entries");

    chk_vector_holds: assert property (
        !take_o |-> $stable(vector_o))
        else $error("vector changed without a transfer");

    chk_ack_onehot: assert property (
        $onehot0(line_ack))
        else $error("more than one line acknowledged");

    chk_ack_then_take: assert property (
        (line_ack != '0) |=> (take_o && vector_o != ext_irq_pkg::NMI_VEC))
        else $error("line acknowledged without a transfer");

    // Event status and register side.
    chk_nmi_status_set: assert property (
        (take_o && vector_o == ext_irq_pkg::NMI_VEC) |-> q.evt_status[ext_irq_pkg::EVT_NMI_BIT])
        else $error("unmaskable transfer not recorded");

    chk_mask_status_set: assert property (
        (take_o && vector_o != ext_irq_pkg::NMI_VEC) |-> q.evt_status[ext_irq_pkg::EVT_MASK_BIT])
        else $error("maskable transfer not recorded");

    chk_rd_upper_zero: assert property (
        avs_readdata_o[ext_irq_pkg::DATA_WIDTH-1:N] == '0)
        else $error("read data carries a bit beyond the nine lines");

    cov_nmi_taken: cover property (take_o && vector_o == ext_irq_pkg::NMI_VEC);
    cov_mask_taken: cover property (take_o && vector_o != ext_irq_pkg::NMI_VEC);
    cov_nmi_preempt: cover property ((take_o && vector_o == ext_irq_pkg::NMI_VEC)
        ##[1:40] (take_o && vector_o == ext_irq_pkg::NMI_VEC));
    cov_irq_raised: cover property ($rose(irq_o));
    cov_mask_after_nmi: cover property ((take_o && vector_o == ext_irq_pkg::NMI_VEC)
        ##[1:60] (take_o && vector_o != ext_irq_pkg::NMI_VEC));

endmodule : ext_irq_front_end

// ===== bench/ext_board_model.sv
module ext_board_model (
    input  wire logic       core_clk_i,
    output logic            nmi_pin_o,
    output logic [8:0]      ext_req_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        nmi_pin_o = 1'b0;
        ext_req_o = 9'h000;
    end

    task pulse_nmi(input int hold);
        @(posedge core_clk_i);
        nmi_pin_o <= 1'b1;
        repeat ((hold < 1) ? 1 : hold) @(posedge core_clk_i);
        nmi_pin_o <= 1'b0;
    endtask : pulse_nmi

    // The pulse leaves the idle level and comes back, so it suits either polarity.
    task pulse_line(input int k, input int hold);
        @(posedge core_clk_i);
        ext_req_o[k] <= ~ext_req_o[k];
        repeat ((hold < 5) ? 5 : hold) @(posedge core_clk_i);
        ext_req_o[k] <= ~ext_req_o[k];
    endtask : pulse_line

    task drive_line(input int k, input logic v);
        @(posedge core_clk_i);
        ext_req_o[k] <= v;
    endtask : drive_line
endmodule : ext_board_model

// ===== bench/external_interrupt_pin_front_end_test.sv
module external_interrupt_pin_front_end_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk_i;
    logic        reset_i;
    logic        boundary;
    logic        set_en;
    logic        clr_en;
    logic        rd;
    logic        wr;
    logic        nmi_pin;
    logic        take;
    logic        gie;
    logic        waitreq;
    logic        irq;
    logic [8:0]  ext_req;
    logic [4:0]  addr;
    logic [7:0]  vec;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] q;
    int          c;
    int          error_cnt;
    int          total_checks;

    ext_board_model board (.core_clk_i(core_clk_i), .nmi_pin_o(nmi_pin), .ext_req_o(ext_req));

    ext_irq_front_end DUT (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .nmi_pin_i(nmi_pin), .ext_req_i(ext_req),
        .instr_boundary_i(boundary), .set_enable_i(set_en), .clear_enable_i(clr_en), .take_o(take),
        .vector_o(vec), .global_enable_o(gie), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(waitreq), .irq_o(irq));

    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    task print_verdict;
        $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    task timeout;
        error_cnt++;
        $display("BAD t=%0t got=%h exp=%h (wait ran out)", $time, 32'h0, 32'h1);
        print_verdict();
    endtask : timeout

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One Avalon transfer; the request holds until waitrequest is seen low at an edge.
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge core_clk_i);
        while (waitreq !== 1'b0) begin
            n++;
            if (n > 20) timeout();
            @(posedge core_clk_i);
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge core_clk_i);
    endtask : bus

    task rd_chk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd_chk

    task pulse_set;
        set_en <= 1'b1;
        @(posedge core_clk_i);
        set_en <= 1'b0;
        @(posedge core_clk_i);
    endtask : pulse_set

    task wait_take(input logic [7:0] v);
        int n;
        n = 0;
        @(posedge core_clk_i);
        while (take !== 1'b1) begin
            n++;
            if (n > 40) timeout();
            @(posedge core_clk_i);
        end
        chk({24'h0, vec}, {24'h0, v});
    endtask : wait_take

    task count_takes(input int cyc);
        c = 0;
        repeat (cyc) begin
            @(posedge core_clk_i);
            if (take === 1'b1) c++;
        end
    endtask : count_takes

    task test_regs;
        rd_chk(ext_irq_pkg::LINE_MASK_OFS, 32'h1ff);
        rd_chk(ext_irq_pkg::LINE_EDGE_OFS, 32'h1ff);
        rd_chk(ext_irq_pkg::LINE_POL_OFS, 32'h1ff);
        rd_chk(ext_irq_pkg::CPU_CTRL_OFS, 32'h0);
        bus(1'b1, ext_irq_pkg::LINE_PEND_OFS, 32'h1ff);
        rd_chk(ext_irq_pkg::LINE_PEND_OFS, 32'h0);
        rd_chk(5'h1c, 32'h0);
        $display("test_regs finished");
    endtask : test_regs

    task test_nmi;
        bus(1'b1, ext_irq_pkg::EVT_MASK_OFS, 32'h1);
        pulse_set();
        chk({31'h0, gie}, 32'h1);
        board.pulse_nmi(1);
        count_takes(10);
        chk(c, 0);
        rd_chk(ext_irq_pkg::LINE_PEND_OFS, 32'h0);
        boundary <= 1'b1;
        wait_take(ext_irq_pkg::NMI_VEC);
        chk({31'h0, gie}, 32'h0);
        count_takes(10);
        chk(c, 0);
        chk({31'h0, irq}, 32'h1);
        rd_chk(ext_irq_pkg::EVT_STATUS_OFS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, ext_irq_pkg::EVT_MASK_OFS, 32'h0);
        // A new request while the global enable is still off must be taken again.
        fork
            board.pulse_nmi(1);
            wait_take(ext_irq_pkg::NMI_VEC);
        join
        tick_irq_low();
        rd_chk(ext_irq_pkg::EVT_STATUS_OFS, 32'h1);
        $display("test_nmi finished");
    endtask : test_nmi

    task tick_irq_low;
        @(posedge core_clk_i);
        chk({31'h0, irq}, 32'h0);
    endtask : tick_irq_low

    task test_lines;
        bus(1'b1, ext_irq_pkg::LINE_MASK_OFS, 32'h0);
        for (int k = 0; k < 9; k++) begin
            pulse_set();
            fork
                board.pulse_line(k, 5);
                wait_take(ext_irq_pkg::MASK_VEC_BASE + 8'(k));
            join
        end
        $display("test_lines finished");
    endtask : test_lines

    task test_prio;
        boundary <= 1'b0;
        pulse_set();
        fork
            board.pulse_nmi(1);
            board.pulse_line(3, 5);
        join
        boundary <= 1'b1;
        wait_take(ext_irq_pkg::NMI_VEC);
        count_takes(8);
        chk(c, 0);
        board.pulse_line(3, 5);
        pulse_set();
        wait_take(ext_irq_pkg::MASK_VEC_BASE + 8'h03);
        pulse_set();
        count_takes(10);
        chk(c, 0);
        rd_chk(ext_irq_pkg::LINE_PEND_OFS, 32'h0);
        $display("test_prio finished");
    endtask : test_prio

    task test_level;
        // Disable first, so the polarity change cannot be taken before it is checked.
        clr_en <= 1'b1;
        @(posedge core_clk_i);
        clr_en <= 1'b0;
        @(posedge core_clk_i);
        chk({31'h0, gie}, 32'h0);
        bus(1'b1, ext_irq_pkg::LINE_EDGE_OFS, 32'h1df);
        bus(1'b1, ext_irq_pkg::LINE_POL_OFS, 32'h1df);
        board.drive_line(5, 1'b1);
        repeat (6) @(posedge core_clk_i);
        rd_chk(ext_irq_pkg::LINE_PEND_OFS, 32'h0);
        board.drive_line(5, 1'b0);
        repeat (6) @(posedge core_clk_i);
        rd_chk(ext_irq_pkg::LINE_PEND_OFS, 32'h20);
        pulse_set();
        wait_take(ext_irq_pkg::MASK_VEC_BASE + 8'h05);
        board.drive_line(5, 1'b1);
        repeat (6) @(posedge core_clk_i);
        rd_chk(ext_irq_pkg::LINE_PEND_OFS, 32'h0);
        $display("test_level finished");
    endtask : test_level

    initial begin
        error_cnt = 0;
        total_checks = 0;
        reset_i = 1'b1;
        boundary = 1'b0;
        set_en = 1'b0;
        clr_en = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 5'h00;
        wdata = 32'h0;
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        test_regs();
        test_nmi();
        test_lines();
        test_prio();
        pulse_set();
        test_level();
        print_verdict();
    end
endmodule : external_interrupt_pin_front_end_test
